/* verilog/slot_addr_pkg.sv */
// package: constants and carrier types for the slot strap address selector
package slot_addr_pkg;
	localparam int STRAP_WIDTH = 4;
	localparam int ADDR_WIDTH = 8;
	// register byte offsets
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STORED_ADDR = 4'h4;
	localparam logic [3:0] OFS_STORED_REPLY = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;
	// field positions
	localparam int CTRL_CANOPEN_BIT = 0;
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_STRAP_BIT = 1;
	localparam int STAT_STRAP_LSB = 8;
	localparam int STAT_ADDR_LSB = 16;
	localparam int STAT_REPLY_LSB = 24;
	// reset values and fixed reply address for strapped slots
	localparam logic [7:0] RST_STORED_ADDR = 8'h01;
	localparam logic [7:0] RST_STORED_REPLY = 8'h02;
	localparam logic [7:0] FIXED_REPLY_ADDR = 8'hFF;
	// cycles after reset release before straps are captured
	localparam int SETTLE_CYCLES = 3;
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// selected addresses as handed to the protocol logic
	typedef struct packed {
		logic valid;
		logic from_strap;
		logic canopen;
		logic [7:0] module_addr;
		logic [7:0] reply_addr;
	} addr_sel_t;

	// axi4-lite write address and data
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} axi_wr_t;

	typedef enum logic [1:0] {
		ST_SETTLE = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_HOLD = 2'b11
	} strap_state_t;
endpackage

/* verilog/strap_sync.sv */
// two-flop synchroniser for the strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1;

	// first flop only feeds the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= '0;
			pin_sync <= '0;
		end else begin
			stage1 <= pin_in;
			pin_sync <= stage1;
		end
	end
endmodule
`default_nettype wire

/* verilog/slot_address_strap_select.sv */
// top: slot strap address selection with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none

module slot_address_strap_select (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// slot strap pins
	input wire logic slot_strap_bit0,
	input wire logic slot_strap_bit1,
	input wire logic slot_strap_bit2,
	input wire logic slot_strap_bit3,
	// axi4-lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// selected addresses for both the can and the rs485 protocol logic
	output slot_addr_pkg::addr_sel_t addr_sel
);
	import slot_addr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		strap_state_t fsm;
		logic [1:0] settle;
		logic [STRAP_WIDTH-1:0] strap;
		logic canopen;
		logic [7:0] stored_addr;
		logic [7:0] stored_reply;
		addr_sel_t sel;
		logic aw_held;
		logic w_held;
		axi_wr_t wr;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t cur;
	state_t next_cur;
	logic [STRAP_WIDTH-1:0] strap_pins;
	logic [STRAP_WIDTH-1:0] strap_sync_q;

	assign strap_pins = {slot_strap_bit3, slot_strap_bit2, slot_strap_bit1, slot_strap_bit0};

	strap_sync #(
		.WIDTH(STRAP_WIDTH)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(strap_pins),
		.pin_sync(strap_sync_q)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// register decode, used by write and read paths
	function automatic logic is_mapped(input logic [3:0] a);
		return (a == OFS_CONTROL) || (a == OFS_STORED_ADDR) ||
			(a == OFS_STORED_REPLY) || (a == OFS_STATUS);
	endfunction

	// byte-lane merge of a write into an 8-bit register
	function automatic logic [7:0] merge_low(input logic [7:0] old, input axi_wr_t w);
		return w.strb[0] ? w.data[7:0] : old;
	endfunction

	// address selection from straps and stored values
	function automatic addr_sel_t select_addr(input logic [STRAP_WIDTH-1:0] s,
		input logic canopen, input logic [7:0] st_addr, input logic [7:0] st_reply);
		addr_sel_t r;
		r.valid = 1'b1;
		r.canopen = canopen;
		if (s != '0) begin
			// strap value 1..15 is address or node id
			r.from_strap = 1'b1;
			r.module_addr = {{(ADDR_WIDTH-STRAP_WIDTH){1'b0}}, s};
			r.reply_addr = FIXED_REPLY_ADDR;
		end else begin
			r.from_strap = 1'b0;
			r.module_addr = st_addr;
			r.reply_addr = st_reply;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		next_cur = cur;
		case (cur.fsm)
			ST_SETTLE: begin
				if (cur.settle == 2'(SETTLE_CYCLES - 1)) begin
					next_cur.fsm = ST_CAPTURE;
				end else begin
					next_cur.settle = cur.settle + 2'h1;
				end
			end
			ST_CAPTURE: begin
				next_cur.strap = strap_sync_q;
				next_cur.fsm = ST_HOLD;
			end
			ST_HOLD: begin
				next_cur.fsm = ST_HOLD;
			end
			default: begin
				next_cur.fsm = ST_SETTLE;
			end
		endcase

		// one selection serves both links, tracks stored values
		if (cur.fsm == ST_HOLD) begin
			next_cur.sel = select_addr(cur.strap, cur.canopen, cur.stored_addr,
				cur.stored_reply);
		end

		// write channel capture
		next_cur.awready = 1'b0;
		next_cur.wready = 1'b0;
		if (s_axi_awvalid && cur.awready) begin
			next_cur.aw_held = 1'b1;
			next_cur.wr.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && cur.wready) begin
			next_cur.w_held = 1'b1;
			next_cur.wr.data = s_axi_wdata;
			next_cur.wr.strb = s_axi_wstrb;
		end
		if (!cur.bvalid && !next_cur.aw_held && !cur.awready) begin
			next_cur.awready = 1'b1;
		end
		if (!cur.bvalid && !next_cur.w_held && !cur.wready) begin
			next_cur.wready = 1'b1;
		end
		if (cur.aw_held && cur.w_held && !cur.bvalid) begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = is_mapped(cur.wr.addr) ? RESP_OKAY : RESP_SLVERR;
			case (cur.wr.addr)
				OFS_CONTROL: begin
					if (cur.wr.strb[0]) begin
						next_cur.canopen = cur.wr.data[CTRL_CANOPEN_BIT];
					end
				end
				OFS_STORED_ADDR: begin
					next_cur.stored_addr = merge_low(cur.stored_addr, cur.wr);
				end
				OFS_STORED_REPLY: begin
					next_cur.stored_reply = merge_low(cur.stored_reply, cur.wr);
				end
				default: begin
				end
			endcase
		end
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
		end

		// read channel
		next_cur.arready = 1'b0;
		if (s_axi_arvalid && cur.arready) begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFS_CONTROL: next_cur.rdata = {31'h0, cur.canopen};
				OFS_STORED_ADDR: next_cur.rdata = {24'h0, cur.stored_addr};
				OFS_STORED_REPLY: next_cur.rdata = {24'h0, cur.stored_reply};
				OFS_STATUS: begin
					next_cur.rdata = 32'h0;
					next_cur.rdata[STAT_VALID_BIT] = cur.sel.valid;
					next_cur.rdata[STAT_STRAP_BIT] = cur.sel.from_strap;
					next_cur.rdata[STAT_STRAP_LSB +: STRAP_WIDTH] = cur.strap;
					next_cur.rdata[STAT_ADDR_LSB +: 8] = cur.sel.module_addr;
					next_cur.rdata[STAT_REPLY_LSB +: 8] = cur.sel.reply_addr;
				end
				default: next_cur.rdata = 32'h0;
			endcase
		end else if (!cur.rvalid && !cur.arready) begin
			next_cur.arready = 1'b1;
		end
		if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
			cur.fsm <= ST_SETTLE;
			cur.stored_addr <= RST_STORED_ADDR;
			cur.stored_reply <= RST_STORED_REPLY;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = cur.awready;
	assign s_axi_wready = cur.wready;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_arready = cur.arready;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata = cur.rdata;
	assign s_axi_rresp = cur.rresp;
	assign addr_sel = cur.sel;

	////////////////////////////////////////////////////////////////////////
	// checks

	// stored address used when straps low
	a_stored_addr_used: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm == ST_HOLD && cur.strap == '0) |=> (addr_sel.module_addr ==
		$past(cur.stored_addr) && !addr_sel.from_strap))
		else $error("stored address not selected");
	// strap address used when any strap high
	a_strap_addr_used: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm == ST_HOLD && cur.strap != '0) |=> (addr_sel.module_addr ==
		{4'h0, $past(cur.strap)}))
		else $error("strap address not selected");
	a_reply_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
		(addr_sel.valid && addr_sel.from_strap) |-> addr_sel.reply_addr == 8'hFF)
		else $error("reply address not 255");
	a_strap_range: assert property (@(posedge aclk) disable iff (!aresetn)
		addr_sel.from_strap |-> (addr_sel.module_addr >= 8'h01 &&
		addr_sel.module_addr <= 8'h0F))
		else $error("strap address out of range");
	a_strap_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm == ST_HOLD) |=> $stable(cur.strap))
		else $error("strap capture changed");
	// selection valid within bound after reset
	a_valid_soon: assert property (@(posedge aclk)
		$rose(aresetn) |-> ##[1:8] addr_sel.valid)
		else $error("selection not valid in time");
	// strap bit order kept through capture
	a_strap_order: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm == ST_CAPTURE) |=> (cur.strap[0] == $past(strap_sync_q[0]) &&
		cur.strap[3] == $past(strap_sync_q[3])))
		else $error("strap bit order wrong");
	a_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.aw_held && cur.w_held && !cur.bvalid) |=> s_axi_bvalid)
		else $error("write response missing");
	// stored reply used when straps low
	a_stored_reply_used: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm == ST_HOLD && cur.strap == '0) |=> (addr_sel.reply_addr ==
		$past(cur.stored_reply)))
		else $error("stored reply address not selected");
	a_mode_passed: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm == ST_HOLD) |=> (addr_sel.canopen == $past(cur.canopen)))
		else $error("mode flag not handed on");
	a_none_early: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.fsm != ST_HOLD) |-> !addr_sel.valid)
		else $error("selection valid before capture");
endmodule
`default_nettype wire

/* tb/slot_strap_model.sv */
// base board slot wiring model: drives a slot value onto the strap pins
`timescale 1ns/1ps
`default_nettype none
module slot_strap_model (
	// slot value chosen by the bench
	input wire logic [3:0] slot_value,
	// strap pins towards the module
	output logic strap_0,
	output logic strap_1,
	output logic strap_2,
	output logic strap_3
);
	assign {strap_3, strap_2, strap_1, strap_0} = slot_value;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench for the slot strap address selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import slot_addr_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] awaddr, araddr, wstrb, slot;
	logic [31:0] wdata, rdata, d, st_a, st_r;
	logic [1:0] bresp, rresp, r;
	logic s0, s1, s2, s3, c;
	addr_sel_t addr_sel, e;
	int failures, checks_done, i;
	integer seed;
	////////////////////////////////////////////////////////////////
	// clock, partner and design
	always #10 aclk = ~aclk;
	slot_strap_model i_slot_strap_model (.slot_value(slot), .strap_0(s0), .strap_1(s1),
		.strap_2(s2), .strap_3(s3));
	slot_address_strap_select i_slot_address_strap_select (.aclk(aclk), .aresetn(aresetn),
		.slot_strap_bit0(s0), .slot_strap_bit1(s1), .slot_strap_bit2(s2),
		.slot_strap_bit3(s3), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .addr_sel(addr_sel));
	////////////////////////////////////////////////////////////////
	// report and compare
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo(input bit ok);
		if (!ok) begin
			failures++;
			give_verdict();
		end
	endtask
	////////////////////////////////////////////////////////////////
	// axi4-lite master cycles, entered just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw, w;
		int n;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		for (n = 0; n < 50 && (aw || w); n++) begin
			@(posedge aclk);
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 0;
			end
		end
		tmo(!aw && !w);
		bready <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
		resp = bresp;
		bready <= 0;
		tmo(n < 50);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		araddr <= a;
		arvalid <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
		tmo(n < 50);
		arvalid <= 0;
		rready <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
		v = rdata;
		resp = rresp;
		rready <= 0;
		tmo(n < 50);
	endtask
	////////////////////////////////////////////////////////////////
	// reset with a given slot value, then wait for the capture
	task automatic do_reset(input logic [3:0] s);
		int n;
		aresetn <= 0;
		slot <= s;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (addr_sel.valid !== 1'b1 && n < 50);
		tmo(n < 50);
		chk(32'(n <= 10), 32'h1);
	endtask
	// expected selection from straps, mode and stored values
	function automatic addr_sel_t exp_sel(input logic [3:0] s, input logic cm,
		input logic [7:0] a, input logic [7:0] p);
		exp_sel.valid = 1'b1;
		exp_sel.from_strap = |s;
		exp_sel.canopen = cm;
		exp_sel.module_addr = (|s) ? {4'h0, s} : a;
		exp_sel.reply_addr = (|s) ? FIXED_REPLY_ADDR : p;
	endfunction
	////////////////////////////////////////////////////////////////
	// main sequence: every slot value, random stored values and mode
	initial begin
		aclk = 0;
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		slot = 4'h0;
		failures = 0;
		checks_done = 0;
		seed = 77194;
		for (i = 0; i < 16; i++) begin
			do_reset(i[3:0]);
			e = exp_sel(i[3:0], 1'b0, RST_STORED_ADDR, RST_STORED_REPLY);
			chk(32'(addr_sel), 32'(e));
			rd(OFS_STORED_REPLY, d, r);
			chk(d, {24'h0, RST_STORED_REPLY});
			st_a = $random(seed);
			st_r = $random(seed);
			c = st_a[9];
			wr(OFS_STORED_ADDR, st_a, r);
			chk(32'(r), 32'(RESP_OKAY));
			wr(OFS_STORED_REPLY, st_r, r);
			chk(32'(r), 32'(RESP_OKAY));
			wr(OFS_CONTROL, {31'h0, c}, r);
			chk(32'(r), 32'(RESP_OKAY));
			wr(OFS_STATUS, st_r, r);
			chk(32'(r), 32'(RESP_OKAY));
			// unmapped offsets answer with an error and no data
			wr(4'h2, st_r, r);
			chk(32'(r), 32'(RESP_SLVERR));
			rd(4'h2, d, r);
			chk(d, 32'h0);
			chk(32'(r), 32'(RESP_SLVERR));
			rd(OFS_STORED_ADDR, d, r);
			chk(d, {24'h0, st_a[7:0]});
			// a write without byte lane 0 leaves the stored address alone
			wstrb <= 4'hE;
			wr(OFS_STORED_ADDR, ~st_a, r);
			wstrb <= 4'hF;
			rd(OFS_STORED_ADDR, d, r);
			chk(d, {24'h0, st_a[7:0]});
			// straps moved after capture are ignored
			slot <= ~i[3:0];
			repeat (4) @(posedge aclk);
			e = exp_sel(i[3:0], c, st_a[7:0], st_r[7:0]);
			chk(32'(addr_sel), 32'(e));
			rd(OFS_STATUS, d, r);
			chk(d, {e.reply_addr, e.module_addr, 4'h0, i[3:0], 6'h00, e.from_strap, 1'b1});
			chk(32'(r), 32'(RESP_OKAY));
		end
		give_verdict();
	end
endmodule
`default_nettype wire
